/* File: dv/pmbus_host_model.sv */
// Host side of the command port: issues decoded PMBus reads and writes.
// Assumes the block takes a command on the edge where valid is high.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input  wire logic                                mclk_in, // Control clock
  output var  turn_on_timing_pkg::cmd_req_type     cmd_out  // Command to the block
);
  initial cmd_out = '0;

  // One command per call; the request stands for exactly one taking edge,
  // then the data lines are scrambled so no stale value looks valid
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk_in);
    cmd_out <= '{valid: 1'b1, write: wr, code: code, data: data};
    @(posedge mclk_in);
    cmd_out <= '{valid: 1'b0, write: 1'b0, code: ~code, data: ~data};
  endtask
endmodule
`default_nettype wire

/* File: dv/turn_on_timing_control_tb.sv */
// Self-checking bench: register access, refusals, restore and one startup.
// Assumes the host model in pmbus_host_model drives the command port.
`timescale 1ns/1ps
`default_nettype none
module turn_on_timing_control_tb;
  logic                            mclk_in = 1'b0;
  logic                            rst_in = 1'b1;
  turn_on_timing_pkg::cmd_req_type cmd;
  turn_on_timing_pkg::status_type  status_out;
  logic [15:0]                     rdata_out;
  logic                            rvalid_out;
  logic                            restore_valid_in = 1'b0;
  logic [7:0]                      restore_code_in = 8'h00;
  logic [15:0]                     restore_data_in = 16'h0000;
  logic                            strap_valid_in = 1'b1;
  logic [6:0]                      strap_ramp_in = 7'h05;
  logic                            start_in = 1'b0;
  logic                            vout_85_in = 1'b0;
  logic                            clear_faults_in = 1'b0;
  logic [15:0]                     ref_dac_out;
  logic                            power_on_out;
  logic                            uv_enable_out;
  logic                            alert_out;
  int                              n_fail = 0;
  int                              checks_done = 0;

  // 200 MHz control clock
  always #2.5 mclk_in = ~mclk_in;

  pmbus_host_model u_host (.mclk_in(mclk_in), .cmd_out(cmd));

  // Strap present, so the strapped rise replaces the stored default
  turn_on_timing_control #(.RAMP_MAN_DEFAULT(11'h002)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .restore_valid_in(restore_valid_in),
    .restore_code_in(restore_code_in), .restore_data_in(restore_data_in),
    .strap_valid_in(strap_valid_in), .strap_ramp_in(strap_ramp_in), .start_in(start_in),
    .vout_85_in(vout_85_in), .vout_target_in(16'h0400), .clear_faults_in(clear_faults_in),
    .ref_dac_out(ref_dac_out), .power_on_out(power_on_out), .uv_enable_out(uv_enable_out),
    .status_out(status_out), .alert_out(alert_out));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Read answers on the taking edge itself and lasts one cycle
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    u_host.send(1'b0, code, 16'h0000);
    #1;
    check("rvalid", {15'h0000, rvalid_out}, 16'h0001);
    check("rdata", rdata_out, exp);
  endtask

  // Status shows one cycle after the write; cleared afterwards
  task automatic wr_stat(input logic [7:0] code, input logic [15:0] d, input logic [4:0] exp);
    u_host.send(1'b1, code, d);
    #1;
    check("status", {11'h000, status_out}, {11'h000, exp});
    check("alert", {15'h0000, alert_out}, {15'h0000, |exp});
    @(posedge mclk_in);
    clear_faults_in <= 1'b1;
    @(posedge mclk_in);
    clear_faults_in <= 1'b0;
  endtask

  task automatic restore(input logic [7:0] code, input logic [15:0] d);
    @(posedge mclk_in);
    restore_valid_in <= 1'b1;
    restore_code_in <= code;
    restore_data_in <= d;
    @(posedge mclk_in);
    restore_valid_in <= 1'b0;
    restore_data_in <= ~d;
  endtask

  // Rise is read last: the strap lands a few edges after reset
  task automatic t_reset_values;
    rd(8'h60, 16'hF800);
    rd(8'h62, 16'hF800);
    rd(8'h63, 16'h0000);
    rd(8'h61, 16'hF005);
    $display("test reset_values done");
  endtask

  task automatic t_write_refuse;
    wr_stat(8'h60, 16'h0802, 5'h00);
    rd(8'h60, 16'hF808);
    wr_stat(8'h60, 16'hF001, 5'h02);
    wr_stat(8'h60, 16'h0100, 5'h02);
    rd(8'h60, 16'hF808);
    wr_stat(8'h61, 16'hF07F, 5'h00);
    rd(8'h61, 16'hF07F);
    wr_stat(8'h61, 16'h0040, 5'h02);
    wr_stat(8'h61, 16'hF002, 5'h00);
    wr_stat(8'h62, 16'hF802, 5'h01);
    rd(8'h62, 16'hF800);
    $display("test write_refuse done");
  endtask

  // Every response, retry and wait code, then the invalid response code
  task automatic t_action_codes;
    logic [7:0] a;
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 8; k++) begin
        a = {s[1:0], k[2:0], 3'(7 - k)};
        wr_stat(8'h63, {8'h00, a}, 5'h00);
        rd(8'h63, {8'h00, a});
      end
    end
    wr_stat(8'h63, 16'h00C0, 5'h02);
    rd(8'h63, 16'h00B8);
    $display("test action_codes done");
  endtask

  task automatic t_restore;
    restore(8'h60, 16'hE003);
    rd(8'h60, 16'hF800);
    restore(8'h62, 16'hF801);
    rd(8'h62, 16'hF801);
    $display("test restore done");
  endtask

  // Zero delay, half-ms rise, half-ms limit, ignore action, sense never reaches 85 pct
  task automatic t_startup;
    int n;
    int t_uv;
    int t_flt;
    t_uv = 0;
    t_flt = 0;
    wr_stat(8'h63, 16'h0000, 5'h00);
    @(posedge mclk_in);
    start_in <= 1'b1;
    for (n = 0; n < 30000 && power_on_out !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    if (n == 30000) begin
      n_fail++;
      print_verdict();
    end
    check("delay", {15'h0000, n >= 19700 && n <= 20400}, 16'h0001);
    for (n = 1; n < 110000 && (t_uv == 0 || t_flt == 0); n++) begin
      @(posedge mclk_in);
      #1;
      if (t_uv == 0 && uv_enable_out === 1'b1) t_uv = n;
      if (t_uv == n) check("ramp_end_dac", ref_dac_out, 16'h0400);
      if (t_flt == 0 && status_out.vout_timeout === 1'b1) t_flt = n;
    end
    if (t_uv == 0 || t_flt == 0) begin
      n_fail++;
      print_verdict();
    end
    check("rise", {15'h0000, t_uv >= 99500 && t_uv <= 100500}, 16'h0001);
    check("limit", {15'h0000, t_flt >= 99500 && t_flt <= 100500}, 16'h0001);
    check("fault", {11'h000, status_out}, 16'h001C);
    check("ignored", {15'h0000, power_on_out}, 16'h0001);
    @(posedge mclk_in);
    start_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    #1;
    check("off_dac", ref_dac_out, 16'h0000);
    $display("test startup done");
  endtask

  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset_values();
    t_write_refuse();
    t_action_codes();
    t_restore();
    t_startup();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: dv/turn_on_timing_monitor.sv */
// Checker for the turn-on sequencer, watching only the top module's ports.
// Assumes one clock domain and the synchronous reset of that domain.
`timescale 1ns/1ps
`default_nettype none
module turn_on_timing_monitor (
  input wire logic                             mclk_in,
  input wire logic                             rst_in,
  input wire turn_on_timing_pkg::cmd_req_type  cmd_in,
  input wire logic                             rvalid_out,
  input wire logic                             start_in,
  input wire logic [15:0]                      vout_target_in,
  input wire logic [15:0]                      ref_dac_out,
  input wire logic                             power_on_out,
  input wire logic                             uv_enable_out,
  input wire turn_on_timing_pkg::status_type   status_out,
  input wire logic                             alert_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [19:0] on_wait_q;
  logic [19:0] on_wait_d;

  // Cycles since start was seen while the stage is off; saturates
  assign on_wait_d = (!start_in || power_on_out) ? 20'h00000 :
                     (&on_wait_q) ? on_wait_q : on_wait_q + 20'h00001;
  always_ff @(posedge mclk_in) begin
    on_wait_q <= rst_in ? 20'h00000 : on_wait_d;
  end

  sequence read_known;
    cmd_in.valid && !cmd_in.write && cmd_in.code >= 8'h60 && cmd_in.code <= 8'h63;
  endsequence
  sequence ramp_step;
    power_on_out && !uv_enable_out && $past(power_on_out) && !$past(uv_enable_out);
  endsequence

  read_answer_a: assert property (read_known |=> rvalid_out)
    else $error("read of a known code gave no answer");
  limit_write_a: assert property (cmd_in.valid && cmd_in.write && cmd_in.code == 8'h62
    |=> status_out.cml_cmd) else $error("limit write not flagged");
  action_invalid_a: assert property (cmd_in.valid && cmd_in.write && cmd_in.code == 8'h63
    && cmd_in.data[7:6] == 2'h3 |=> status_out.cml_data)
    else $error("invalid action code not flagged");
  delay_step_a: assert property (cmd_in.valid && cmd_in.write && cmd_in.code == 8'h60
    && cmd_in.data[15:11] == 5'h1E && cmd_in.data[0] |=> status_out.cml_data)
    else $error("quarter step delay not flagged");
  uv_after_ramp_a: assert property (uv_enable_out |-> power_on_out)
    else $error("undervoltage enabled with stage off");
  ramp_target_a: assert property ($rose(uv_enable_out) |-> ref_dac_out == vout_target_in)
    else $error("ramp did not end at target");
  ramp_rising_a: assert property (ramp_step |-> ref_dac_out >= $past(ref_dac_out))
    else $error("reference fell during ramp");
  min_delay_a: assert property ($rose(power_on_out) |-> on_wait_q >= 20'h04CF4)
    else $error("rise began before minimum delay");
  fault_set_a: assert property ($rose(status_out.vout_timeout) |->
    status_out.none_above && status_out.word_vout && alert_out)
    else $error("timeout fault status incomplete");
  fault_when_on_a: assert property ($rose(status_out.vout_timeout) |-> $past(power_on_out))
    else $error("timeout fault before delay end");
endmodule
bind turn_on_timing_control turn_on_timing_monitor u_monitor (
  .mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd_in), .rvalid_out(rvalid_out),
  .start_in(start_in), .vout_target_in(vout_target_in), .ref_dac_out(ref_dac_out),
  .power_on_out(power_on_out), .uv_enable_out(uv_enable_out), .status_out(status_out),
  .alert_out(alert_out));
`default_nettype wire

/* File: hw/turn_on_timing_control.sv */
// Turn-on sequencer: delay, soft-start ramp of the reference, startup timeout.
// Commands arrive decoded from a PMBus front end on mclk_in; start and strap
// pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module turn_on_timing_control #(
  parameter logic [10:0] DELAY_MAN_DEFAULT   = 11'h000, // Stored delay, half-ms units
  parameter logic [10:0] RAMP_MAN_DEFAULT    = 11'h014, // Stored rise, quarter-ms units
  parameter logic [10:0] TIMEOUT_MAN_DEFAULT = 11'h000, // Stored limit, half-ms units
  parameter logic [7:0]  ACTION_DEFAULT      = 8'h00    // Stored action byte
) (
  input  wire  logic                           mclk_in,          // Control clock
  input  wire  logic                           rst_in,           // Sync reset, high
  input  wire  turn_on_timing_pkg::cmd_req_type cmd_in,          // Decoded command
  output logic [15:0]                          rdata_out,        // Read data
  output logic                                 rvalid_out,       // Read data valid
  input  wire  logic                           restore_valid_in, // Stored word load
  input  wire  logic [7:0]                     restore_code_in,  // Its command code
  input  wire  logic [15:0]                    restore_data_in,  // Its value
  input  wire  logic                           strap_valid_in,   // Rise strap present
  input  wire  logic [6:0]                     strap_ramp_in,    // Strapped rise
  input  wire  logic                           start_in,         // On/off start level
  input  wire  logic                           vout_85_in,       // Sense above 85 pct
  input  wire  logic [15:0]                    vout_target_in,   // Target DAC code
  input  wire  logic                           clear_faults_in,  // Clear status
  output logic [15:0]                          ref_dac_out,      // Reference DAC code
  output logic                                 power_on_out,     // Stage switching
  output logic                                 uv_enable_out,    // UV detect enable
  output turn_on_timing_pkg::status_type        status_out,       // Sticky status
  output logic                                 alert_out         // Host notify
);
  typedef enum logic [5:0] {
    ST_OFF = 6'h01, ST_DELAY = 6'h02, ST_RISE = 6'h04,
    ST_ON  = 6'h08, ST_HICCUP = 6'h10, ST_LATCH = 6'h20
  } seq_state_type;

  // Linear word to quarter milliseconds, rounded; bit 18 flags inexact, too large
  // (saturated) or negative, negative yields zero so that restore clamps low
  function automatic logic [18:0] to_quarters(input logic [15:0] w);
    logic [5:0]  e;
    logic [4:0]  sh;
    logic [17:0] q;
    logic [17:0] half;
    logic [10:0] mask;
    e = {w[15], w[15:11]} + 6'h02;
    sh = 5'h00;
    q = 18'h00000;
    half = 18'h00000;
    mask = 11'h000;
    if (w[10]) begin
      to_quarters = {1'b1, 18'h00000};
    end else if (!e[5]) begin
      if (e > 6'h07) begin
        to_quarters = {1'b1, 18'h3FFFF};
      end else begin
        to_quarters = {1'b0, 18'({7'h00, w[10:0]} << e[2:0])};
      end
    end else begin
      sh = 5'(6'h00 - e);
      half = 18'h00001 << (sh - 5'h01);
      q = ({7'h00, w[10:0]} + half) >> sh;
      mask = (sh > 5'h0A) ? 11'h7FF : 11'((12'h001 << sh) - 12'h001);
      to_quarters = {|(w[10:0] & mask), q};
    end
  endfunction

  // Pin synchronisers
  logic [1:0]  start_sync_q;
  logic [1:0]  strap_vld_sync_q;
  logic [13:0] strap_sync_q;
  always_ff @(posedge mclk_in) begin
    start_sync_q     <= {start_sync_q[0], start_in};
    strap_vld_sync_q <= {strap_vld_sync_q[0], strap_valid_in};
    strap_sync_q     <= {strap_sync_q[6:0], strap_ramp_in};
  end
  wire start_w = start_sync_q[1];

  // Microsecond tick divider
  logic [7:0] div_q;
  wire        tick_w = (div_q == 8'(turn_on_timing_pkg::TICK_CYCLES - 1));
  always_ff @(posedge mclk_in) begin
    if (rst_in || tick_w) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // Command decode
  wire        wr_w   = cmd_in.valid && cmd_in.write;
  wire        rd_w   = cmd_in.valid && !cmd_in.write;
  wire        is_dly = cmd_in.code == turn_on_timing_pkg::CMD_DELAY;
  wire        is_rmp = cmd_in.code == turn_on_timing_pkg::CMD_RAMP;
  wire        is_tmo = cmd_in.code == turn_on_timing_pkg::CMD_TIMEOUT;
  wire        is_act = cmd_in.code == turn_on_timing_pkg::CMD_ACTION;
  wire        known_w = is_dly || is_rmp || is_tmo || is_act;
  wire [18:0] wq_w   = to_quarters(cmd_in.data);
  wire        dly_ok = !wq_w[18] && !wq_w[0]
                       && wq_w[17:0] <= turn_on_timing_pkg::DELAY_Q_MAX;
  wire        rmp_ok = !wq_w[18] && wq_w[17:0] <= turn_on_timing_pkg::RAMP_Q_MAX;
  wire        act_ok = cmd_in.data[7:6] != 2'h3;
  wire        dly_wr = wr_w && is_dly && dly_ok;
  wire        rmp_wr = wr_w && is_rmp && rmp_ok;
  wire        act_wr = wr_w && is_act && act_ok;
  wire        bad_data_w = wr_w && ((is_dly && !dly_ok) || (is_rmp && !rmp_ok)
                                    || (is_act && !act_ok));
  wire        bad_cmd_w  = cmd_in.valid && (!known_w || (cmd_in.write && is_tmo));

  // Restore: round to the nearest supported value and clamp to range
  wire [18:0] rq_w   = to_quarters(restore_data_in);
  // One less exponent gives half-ms units directly; going through quarters
  // first would round twice and could land one step high
  wire [4:0]  rh_exp  = restore_data_in[15:11] - 5'h01;
  wire [15:0] rh_word = (restore_data_in[15:11] == 5'h10) ? 16'h0000
                        : {rh_exp, restore_data_in[10:0]};
  wire [18:0] rh_w    = to_quarters(rh_word);
  wire [17:0] rq_half = rh_w[17:0];
  wire        rs_dly = restore_valid_in && restore_code_in == turn_on_timing_pkg::CMD_DELAY;
  wire        rs_rmp = restore_valid_in && restore_code_in == turn_on_timing_pkg::CMD_RAMP;
  wire        rs_tmo = restore_valid_in
                       && restore_code_in == turn_on_timing_pkg::CMD_TIMEOUT;
  wire        rs_act = restore_valid_in && restore_code_in == turn_on_timing_pkg::CMD_ACTION
                       && restore_data_in[7:6] != 2'h3;
  wire [10:0] rs_dly_man = (rq_half > 18'h000FF) ? 11'h0FF : rq_half[10:0];
  wire [10:0] rs_rmp_man = (rq_w[17:0] > turn_on_timing_pkg::RAMP_Q_MAX)
                           ? 11'h07F : rq_w[10:0];
  wire [10:0] rs_tmo_man = (rq_half > 18'h000FE) ? 11'h0FE : rq_half[10:0];

  // Settings, held in canonical form; writes take effect at once
  logic [10:0] dly_man_q;
  logic [10:0] rmp_man_q;
  logic [10:0] tmo_man_q;
  logic [7:0]  act_q;
  logic [2:0]  strap_cnt_q;
  wire         strap_take_w = (strap_cnt_q == 3'h3) && strap_vld_sync_q[1];
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      dly_man_q   <= DELAY_MAN_DEFAULT;
      rmp_man_q   <= RAMP_MAN_DEFAULT;
      tmo_man_q   <= TIMEOUT_MAN_DEFAULT;
      act_q       <= ACTION_DEFAULT;
      strap_cnt_q <= 3'h0;
    end else begin
      if (strap_cnt_q != 3'h4) strap_cnt_q <= strap_cnt_q + 3'h1;
      if (dly_wr) dly_man_q <= wq_w[11:1];
      else if (rs_dly) dly_man_q <= rs_dly_man;
      if (rmp_wr) rmp_man_q <= wq_w[10:0];
      else if (strap_take_w) rmp_man_q <= {4'h0, strap_sync_q[13:7]};
      else if (rs_rmp) rmp_man_q <= rs_rmp_man;
      if (rs_tmo) tmo_man_q <= rs_tmo_man;
      if (act_wr) act_q <= cmd_in.data[7:0];
      else if (rs_act) act_q <= restore_data_in[7:0];
    end
  end

  // Read port, one cycle after the request
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out  <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_w && known_w;
      if (rd_w && is_dly) rdata_out <= {turn_on_timing_pkg::DELAY_EXP, dly_man_q};
      if (rd_w && is_rmp) rdata_out <= {turn_on_timing_pkg::RAMP_EXP, rmp_man_q};
      if (rd_w && is_tmo) rdata_out <= {turn_on_timing_pkg::TIMEOUT_EXP, tmo_man_q};
      if (rd_w && is_act) rdata_out <= {8'h00, act_q};
    end
  end

  // Durations in microsecond ticks
  wire [10:0] rmp_eff = (rmp_man_q < turn_on_timing_pkg::RAMP_MAN_MIN)
                        ? turn_on_timing_pkg::RAMP_MAN_MIN : rmp_man_q;
  wire [17:0] dly_us  = 18'(dly_man_q * turn_on_timing_pkg::HALF_MS_US);
  wire [17:0] dly_eff = (dly_us < turn_on_timing_pkg::INIT_DELAY_US)
                        ? turn_on_timing_pkg::INIT_DELAY_US : dly_us;
  wire [17:0] rmp_us  = 18'(rmp_eff * turn_on_timing_pkg::QUARTER_MS_US);
  wire [17:0] tmo_us  = 18'(tmo_man_q * turn_on_timing_pkg::HALF_MS_US);
  wire [1:0]  sel_w   = act_q[turn_on_timing_pkg::SEL_HI:turn_on_timing_pkg::SEL_LO];
  wire [2:0]  pol_w   = act_q[turn_on_timing_pkg::POL_HI:turn_on_timing_pkg::POL_LO];
  wire [2:0]  wait_w  = act_q[turn_on_timing_pkg::WAIT_HI:turn_on_timing_pkg::WAIT_LO];
  wire [2:0]  wait_ms = (wait_w == 3'h0) ? 3'h1 : wait_w;
  wire [2:0]  mult_w  = (wait_w == 3'h7) ? 3'h7 : wait_w + 3'h1;
  wire [17:0] wait_us = 18'(wait_ms * turn_on_timing_pkg::MS_US);
  wire [20:0] hic_us  = 21'(mult_w * rmp_us);

  // Sequencer state
  seq_state_type state_q;
  logic [20:0]   tmr_q;
  logic [17:0]   to_cnt_q;
  logic          to_run_q;
  logic          pend_q;
  logic [17:0]   pend_cnt_q;
  logic [2:0]    tries_q;
  logic [17:0]   acc_q;
  logic [17:0]   acc_d;

  wire to_fault_w = to_run_q && tmo_us != 18'h00000 && !vout_85_in
                    && to_cnt_q >= tmo_us;
  wire pend_done  = pend_q && tick_w && pend_cnt_q + 18'h00001 >= wait_us;
  wire shut_now   = (to_fault_w && sel_w == turn_on_timing_pkg::SEL_IMMEDIATE)
                    || (pend_done && !vout_85_in);
  wire give_up    = pol_w == turn_on_timing_pkg::POL_LATCH
                    || (pol_w != turn_on_timing_pkg::POL_FOREVER && tries_q >= pol_w);
  wire dly_done   = tick_w && tmr_q + 21'h000001 >= {3'h0, dly_eff};
  wire rise_done  = tick_w && tmr_q + 21'h000001 >= {3'h0, rmp_us};
  wire hic_done   = tick_w && tmr_q + 21'h000001 >= hic_us;
  wire ramp_more  = acc_q >= rmp_us && ref_dac_out < vout_target_in;

  // Fractional accumulator: each tick adds the target, each overflow steps
  // the DAC by one code; at most one step per clock limits the slope
  always_comb begin
    acc_d = acc_q;
    if (ramp_more) acc_d = acc_q - rmp_us;
    if (tick_w) acc_d = acc_d + {2'h0, vout_target_in};
  end

  // Sequence flow: off, delay, rise, on, hiccup, latched off
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q     <= ST_OFF;
      tmr_q       <= 21'h000000;
      tries_q     <= 3'h0;
      acc_q       <= 18'h00000;
      ref_dac_out <= 16'h0000;
    end else begin
      if (tick_w) tmr_q <= tmr_q + 21'h000001;
      unique case (state_q)
        ST_OFF: begin
          tmr_q   <= 21'h000000;
          tries_q <= 3'h0;
          if (start_w) state_q <= ST_DELAY;
        end
        ST_DELAY: if (dly_done) begin
          state_q     <= ST_RISE;
          tmr_q       <= 21'h000000;
          acc_q       <= 18'h00000;
          ref_dac_out <= 16'h0000;
        end
        ST_RISE: begin
          acc_q <= acc_d;
          if (ramp_more) ref_dac_out <= ref_dac_out + 16'h0001;
          if (rise_done) begin
            state_q     <= ST_ON;
            ref_dac_out <= vout_target_in;
          end
        end
        ST_ON: ref_dac_out <= vout_target_in;
        ST_HICCUP: if (hic_done) begin
          state_q <= ST_DELAY;
          tmr_q   <= 21'h000000;
        end
        ST_LATCH: ;
      endcase
      if (shut_now && (state_q == ST_RISE || state_q == ST_ON)) begin
        ref_dac_out <= 16'h0000;
        tmr_q       <= 21'h000000;
        state_q     <= give_up ? ST_LATCH : ST_HICCUP;
        if (!give_up && tries_q != 3'h7) tries_q <= tries_q + 3'h1;
      end
      if (vout_85_in && state_q == ST_ON) tries_q <= 3'h0;
      if (!start_w) begin
        state_q     <= ST_OFF;
        ref_dac_out <= 16'h0000;
      end
    end
  end

  // Startup timeout runs from the end of the delay until 85 percent
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      to_run_q   <= 1'b0;
      to_cnt_q   <= 18'h00000;
      pend_q     <= 1'b0;
      pend_cnt_q <= 18'h00000;
    end else begin
      if (state_q == ST_DELAY && dly_done) begin
        to_run_q <= 1'b1;
        to_cnt_q <= 18'h00000;
      end else if (to_fault_w || vout_85_in || !(state_q == ST_RISE || state_q == ST_ON)) begin
        to_run_q <= 1'b0;
      end else if (tick_w) begin
        to_cnt_q <= to_cnt_q + 18'h00001;
      end
      if (to_fault_w && sel_w == turn_on_timing_pkg::SEL_DELAYED) begin
        pend_q     <= 1'b1;
        pend_cnt_q <= 18'h00000;
      end else if (pend_done || !(state_q == ST_RISE || state_q == ST_ON)) begin
        pend_q <= 1'b0;
      end else if (tick_w) begin
        pend_cnt_q <= pend_cnt_q + 18'h00001;
      end
    end
  end

  // Sticky status; a new event in the clearing cycle survives the clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_out <= '0;
    end else begin
      status_out.none_above   <= (status_out.none_above && !clear_faults_in) || to_fault_w;
      status_out.word_vout    <= (status_out.word_vout && !clear_faults_in) || to_fault_w;
      status_out.vout_timeout <= (status_out.vout_timeout && !clear_faults_in) || to_fault_w;
      status_out.cml_data     <= (status_out.cml_data && !clear_faults_in) || bad_data_w;
      status_out.cml_cmd      <= (status_out.cml_cmd && !clear_faults_in) || bad_cmd_w;
    end
  end

  // Outputs decoded from state; alert decoded from sticky status
  assign alert_out     = |status_out;
  assign power_on_out  = state_q == ST_RISE || state_q == ST_ON;
  assign uv_enable_out = state_q == ST_ON;
endmodule
`default_nettype wire

/* File: hw/turn_on_timing_pkg.sv */
// Constants, field layouts and carrier types for the turn-on timing block.
// Assumes a PMBus front end that decodes transactions into single-cycle
// command requests on the block's own clock.
//
// Functional notes
// - Wait programmed delay after start, then rise.
// - Delay is a linear-format word, read and write.
// - Delay spans 0 to 127.5 ms, half-ms steps.
// - At least about 100 us delay always.
// - Restore rounds delay to nearest supported value.
// - Out-of-range delay or rise write is rejected, flagged.
// - Whole converter, live updates, nonvolatile backed settings.
// - Reference ramps into band in exactly rise time.
// - Rise 0 to 31.75 ms; below 0.5 ms uses 0.5.
// - Initial rise from storage or pin strap.
// - Slew resolution quantizes long, high-voltage ramps.
// - Timeout from delay end until 85 percent reached.
// - Undervoltage detection enabled only after ramp ends.
// - Timeout limit 0 to 127 ms, half-ms steps.
// - Zero timeout limit disables timeout detection.
// - Writes to timeout limit flagged invalid command.
// - Timeout fault sets three status bits, notifies.
// - Timeout action is one byte, read and write.
// - Bits 7:6 pick ignore, delayed or immediate shutdown.
// - Bits 5:3 pick latch, 1-6 retries, or forever.
// - Bits 2:0 pick shutdown wait and hiccup length.
package turn_on_timing_pkg;
  // Command codes
  localparam logic [7:0]  CMD_DELAY      = 8'h60;
  localparam logic [7:0]  CMD_RAMP       = 8'h61;
  localparam logic [7:0]  CMD_TIMEOUT    = 8'h62;
  localparam logic [7:0]  CMD_ACTION     = 8'h63;
  // Exponents used for stored words, also their reset values
  localparam logic [4:0]  DELAY_EXP      = 5'h1F;
  localparam logic [4:0]  RAMP_EXP       = 5'h1E;
  localparam logic [4:0]  TIMEOUT_EXP    = 5'h1F;
  // Supported ranges, in quarter milliseconds
  localparam logic [17:0] DELAY_Q_MAX    = 18'h001FE;
  localparam logic [17:0] RAMP_Q_MAX     = 18'h0007F;
  localparam logic [17:0] TIMEOUT_Q_MAX  = 18'h001FC;
  localparam logic [10:0] RAMP_MAN_MIN   = 11'h002;
  // Timing in microseconds; one tick is one microsecond
  localparam int          CLK_MHZ        = 200;
  localparam int          TICK_CYCLES    = CLK_MHZ * 1;
  localparam logic [17:0] INIT_DELAY_US  = 18'h00064;
  localparam logic [17:0] HALF_MS_US     = 18'h001F4;
  localparam logic [17:0] QUARTER_MS_US  = 18'h000FA;
  localparam logic [17:0] MS_US          = 18'h003E8;
  // Action byte fields
  localparam int          SEL_HI         = 7;
  localparam int          SEL_LO         = 6;
  localparam int          POL_HI         = 5;
  localparam int          POL_LO         = 3;
  localparam int          WAIT_HI        = 2;
  localparam int          WAIT_LO        = 0;
  localparam logic [1:0]  SEL_IGNORE     = 2'h0;
  localparam logic [1:0]  SEL_DELAYED    = 2'h1;
  localparam logic [1:0]  SEL_IMMEDIATE  = 2'h2;
  localparam logic [2:0]  POL_LATCH      = 3'h0;
  localparam logic [2:0]  POL_FOREVER    = 3'h7;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_req_type;

  typedef struct packed {
    logic none_above;
    logic word_vout;
    logic vout_timeout;
    logic cml_data;
    logic cml_cmd;
  } status_type;
endpackage
